// >>> src/fap_consts.svh
// Constants of the flash access protection block: register offsets, fields, codes.
// Assumes an APB register bus with byte addresses and 32-bit data.
`ifndef FAP_CONSTS_SVH
`define FAP_CONSTS_SVH

`define FAP_OFS_LEVEL    8'h00
`define FAP_OFS_CTRL     8'h04
`define FAP_OFS_WLOCK    8'h08
`define FAP_OFS_XO       8'h0c
`define FAP_OFS_SEC      8'h10
`define FAP_OFS_ECCADDR  8'h14
`define FAP_OFS_STATUS   8'h18
`define FAP_OFS_CLEAR    8'h1c
`define FAP_OFS_IRQEN    8'h20
`define FAP_OFS_PINS     8'h24

`define FAP_LVL0_CODE    8'haa
`define FAP_LVL2_CODE    8'hcc

`define FAP_CTRL_SECLOCK 0
`define FAP_CTRL_XOWIPE  1

`define FAP_ST_DENY      0
`define FAP_ST_ECC1      1
`define FAP_ST_ECC2      2
`define FAP_ST_SEC       3
`define FAP_ST_W         4

`define FAP_PAGE_W       6
`define FAP_PAGE_LSB     11
`define FAP_AW           18
`define FAP_OTP_BIT      17
`define FAP_WLOCK_RST    32'h0000_003f
`define FAP_XO_RST       32'h0000_003f
`define FAP_SEC_RST      32'h0000_0000

`endif

// >>> src/fap_pkg.sv
// Types of the flash access protection block.
// Assumes fap_consts.svh is on the include path.
package fap_pkg;
    typedef enum logic [1:0] {
        MST_CPU_I = 2'h0,
        MST_CPU_D = 2'h1,
        MST_DMA   = 2'h2,
        MST_DEBUG = 2'h3
    } fap_master_t;

    typedef enum logic [1:0] {
        OP_READ  = 2'h0,
        OP_PROG  = 2'h1,
        OP_ERASE = 2'h2,
        OP_WIPE  = 2'h3
    } fap_op_t;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_READ  = 5'h02,
        ST_BLANK = 5'h04,
        ST_WRITE = 5'h08,
        ST_WIPE  = 5'h10
    } fap_state_t;
endpackage : fap_pkg

// >>> src/fap_ecc.sv
// SECDED code over a 64-bit double word with 8 check bits (word[71:64]).
// Purely combinational; used for both encoding and checking.
`timescale 1ns/1ps
module fap_ecc (
    input  wire logic [63:0] enc_data_i,
    output logic      [7:0]  enc_check_o,
    input  wire logic [71:0] dec_word_i,
    output logic      [63:0] dec_data_o,
    output logic             dec_single_o,
    output logic             dec_double_o
);
    logic [6:0] synd;
    logic       par_err;

    // Code position of data bit idx, skipping powers of two
    function automatic logic [6:0] bit_pos(input int idx);
        int n;
        n = 0;
        bit_pos = 7'h00;
        for (int p = 3; p < 72; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (n == idx) bit_pos = p[6:0];
                n++;
            end
        end
    endfunction : bit_pos

    always_comb begin
        enc_check_o = 8'h00;
        synd        = dec_word_i[70:64];
        for (int i = 0; i < 64; i++) begin
            if (enc_data_i[i]) enc_check_o[6:0] = enc_check_o[6:0] ^ bit_pos(i);
            if (dec_word_i[i]) synd = synd ^ bit_pos(i);
        end
        enc_check_o[7] = ^{enc_data_i, enc_check_o[6:0]};
    end

    assign par_err      = ^dec_word_i;
    assign dec_single_o = par_err;
    assign dec_double_o = ~par_err & (synd != 7'h00);

    // Flip the one data bit the syndrome points at
    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_fix
            assign dec_data_o[g] = dec_word_i[g] ^ (par_err & (synd == bit_pos(g)));
        end
    endgenerate
endmodule : fap_ecc

// >>> src/fap_guard.sv
// Access decision for one flash request against all protection settings.
// Combinational; settings come from registers and synchronised pins of the top, the request straight from its ports.
`timescale 1ns/1ps
`include "fap_consts.svh"
module fap_guard
    import fap_pkg::*;
(
    input  wire logic [`FAP_AW-1:0]     addr_i,
    input  wire fap_master_t            master_i,
    input  wire fap_op_t                op_i,
    input  wire logic                   lvl1_i,
    input  wire logic                   lvl2_i,
    input  wire logic                   dbg_attached_i,
    input  wire logic                   boot_alt_i,
    input  wire logic [31:0]            wlock_i,
    input  wire logic [31:0]            xo_i,
    input  wire logic [31:0]            sec_i,
    input  wire logic                   sec_locked_i,
    output logic                        allow_o,
    output logic                        sec_hit_o
);
    logic [`FAP_PAGE_W-1:0] page;
    logic                   otp;
    logic                   is_write;
    logic                   lvl1_block;
    logic                   dbg_block;
    logic                   in_wlock;
    logic                   in_xo;
    logic                   xo_block;
    logic                   otp_block;

    assign page       = addr_i[`FAP_PAGE_LSB +: `FAP_PAGE_W];
    assign otp        = addr_i[`FAP_OTP_BIT];
    assign is_write   = (op_i != OP_READ);
    assign lvl1_block = lvl1_i & (dbg_attached_i | boot_alt_i);
    assign dbg_block  = lvl2_i & (master_i == MST_DEBUG);
    assign in_wlock   = ~otp & (page >= wlock_i[5:0]) & (page <= wlock_i[13:8]);
    assign in_xo      = ~otp & (page >= xo_i[5:0]) & (page <= xo_i[13:8]);
    assign xo_block   = in_xo & ~((master_i == MST_CPU_I) & (op_i == OP_READ));
    assign sec_hit_o  = ~otp & ({1'b0, page} < sec_i[6:0]) & sec_locked_i;
    assign otp_block  = otp & (op_i == OP_ERASE);
    assign allow_o    = ~lvl1_block & ~dbg_block & ~(in_wlock & is_write)
                      & ~xo_block & ~sec_hit_o & ~otp_block;
endmodule : fap_guard

// >>> src/fap_top.sv
// Flash access protection: guards master requests to the program flash array.
// Assumes one system clock; flash array handshakes on the same clock; pins are async.
//
// Contract
// - Lowest guard level imposes no readout restriction on any master.
// - Middle level refuses all reads and writes with debugger or alternate boot.
// - Highest level disables debug access, RAM boot and bootloader selection.
// - Once highest level is set, any attempt to lower it is rejected.
// - Write lock area refuses erase and program but allows reads.
// - Execute-only area grants only CPU instruction fetches.
// - Dropping middle to lowest level wipes execute-only area if option bit set.
// - Securable area is unlocked after every reset.
// - Locked securable area errors every access until next reset; the SEC register stays writable while locked, so the area can shrink.
// - Every read is ECC checked; single errors corrected, double detected.
// - ECC failure address captured in a readable register.
// - OTP area of 128 double words, written once, never erased; the guard refuses only OP_ERASE there, OP_WIPE requests reach the array.
// - Protected array covers up to 128 Kbytes of code and data.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "fap_consts.svh"
module fap_top
    import fap_pkg::*;
(
    input  wire logic                   clock_i,
    input  wire logic                   rst_i,
    input  wire logic [7:0]             opt_level_i,
    input  wire logic                   dbg_attached_i,
    input  wire logic                   boot_alt_i,
    input  wire logic                   psel_i,
    input  wire logic                   penable_i,
    input  wire logic                   pwrite_i,
    input  wire logic [7:0]             paddr_i,
    input  wire logic [31:0]            pwdata_i,
    output logic      [31:0]            prdata_o,
    output logic                        pready_o,
    output logic                        pslverr_o,
    input  wire logic                   req_valid_i,
    input  wire fap_master_t            req_master_i,
    input  wire fap_op_t                req_op_i,
    input  wire logic [`FAP_AW-1:0]     req_addr_i,
    input  wire logic [63:0]            req_wdata_i,
    output logic                        req_ready_o,
    output logic                        rsp_valid_o,
    output logic                        rsp_err_o,
    output logic      [63:0]            rsp_rdata_o,
    output logic                        fl_req_o,
    output fap_op_t                     fl_op_o,
    output logic      [`FAP_AW-1:0]     fl_addr_o,
    output logic      [71:0]            fl_wdata_o,
    input  wire logic                   fl_ack_i,
    input  wire logic [71:0]            fl_rdata_i,
    output logic                        dbg_port_off_o,
    output logic                        boot_sel_lock_o,
    output logic                        irq_o
);
    fap_state_t               state_reg;
    logic [1:0]               sync1_reg;
    logic [1:0]               sync2_reg;
    logic                     loaded_reg;
    logic [7:0]               level_reg;
    logic [1:0]               ctrl_reg;
    logic [31:0]              wlock_reg;
    logic [31:0]              xo_reg;
    logic [31:0]              sec_reg;
    logic [`FAP_AW-1:0]       eccaddr_reg;
    logic [4:0]               status_reg;
    logic [4:0]               irqen_reg;
    logic [4:0]               ev_reg;
    logic                     wipe_pend_reg;
    logic                     pready_reg;
    logic                     pslverr_reg;
    logic [31:0]              prdata_reg;
    logic                     req_ready_reg;
    logic                     rsp_valid_reg;
    logic                     rsp_err_reg;
    logic [63:0]              rsp_rdata_reg;
    logic                     fl_req_reg;
    fap_op_t                  fl_op_reg;
    logic [`FAP_AW-1:0]       fl_addr_reg;
    logic [71:0]              fl_wdata_reg;
    logic                     dbg_off_reg;
    logic                     boot_lock_reg;
    logic                     irq_reg;
    logic [63:0]              wdata_hold_reg;

    wire        dbg_s = sync2_reg[0];
    wire        boot_s = sync2_reg[1];
    wire        lvl0 = (level_reg == `FAP_LVL0_CODE);
    wire        lvl2 = (level_reg == `FAP_LVL2_CODE);
    wire        lvl1 = ~lvl0 & ~lvl2;
    wire        apb_setup = psel_i & ~penable_i;
    wire        apb_wr = psel_i & penable_i & pready_reg & pwrite_i;
    wire        hit_level = (paddr_i == `FAP_OFS_LEVEL);
    wire        hit_ctrl = (paddr_i == `FAP_OFS_CTRL);
    wire        hit_wlock = (paddr_i == `FAP_OFS_WLOCK);
    wire        hit_xo = (paddr_i == `FAP_OFS_XO);
    wire        hit_sec = (paddr_i == `FAP_OFS_SEC);
    wire        hit_eccaddr = (paddr_i == `FAP_OFS_ECCADDR);
    wire        hit_status = (paddr_i == `FAP_OFS_STATUS);
    wire        hit_clear = (paddr_i == `FAP_OFS_CLEAR);
    wire        hit_irqen = (paddr_i == `FAP_OFS_IRQEN);
    wire        hit_pins = (paddr_i == `FAP_OFS_PINS);
    wire        hit_any = hit_level | hit_ctrl | hit_wlock | hit_xo | hit_sec | hit_eccaddr
                          | hit_status | hit_clear | hit_irqen | hit_pins;
    wire [4:0]  clr_mask = (apb_wr & hit_clear) ? pwdata_i[4:0] : 5'h00;
    wire        lvl_refused = lvl2 & (pwdata_i[7:0] != `FAP_LVL2_CODE);
    wire        lvl_wr = apb_wr & hit_level & ~lvl_refused;
    wire        wipe_req = lvl_wr & lvl1 & (pwdata_i[7:0] == `FAP_LVL0_CODE)
                           & ctrl_reg[`FAP_CTRL_XOWIPE];
    wire        wipe_done = (state_reg == ST_WIPE) & fl_ack_i;
    wire        take = (state_reg == ST_IDLE) & ~wipe_pend_reg & req_valid_i & req_ready_reg;
    wire        allow;
    wire        sec_hit;
    wire [7:0]  enc_check;
    wire [63:0] dec_data;
    wire        dec_single;
    wire        dec_double;
    wire        blank = &fl_rdata_i;
    wire [31:0] rd_mux = hit_level   ? {24'h0, level_reg} :
                         hit_ctrl    ? {30'h0, ctrl_reg} :
                         hit_wlock   ? wlock_reg :
                         hit_xo      ? xo_reg :
                         hit_sec     ? sec_reg :
                         hit_eccaddr ? {14'h0, eccaddr_reg} :
                         hit_status  ? {27'h0, status_reg} :
                         hit_irqen   ? {27'h0, irqen_reg} :
                         hit_pins    ? {29'h0, lvl2, boot_s, dbg_s} : 32'h0;

    fap_guard u_guard (
        .addr_i         (req_addr_i),
        .master_i       (req_master_i),
        .op_i           (req_op_i),
        .lvl1_i         (lvl1),
        .lvl2_i         (lvl2),
        .dbg_attached_i (dbg_s),
        .boot_alt_i     (boot_s),
        .wlock_i        (wlock_reg),
        .xo_i           (xo_reg),
        .sec_i          (sec_reg),
        .sec_locked_i   (ctrl_reg[`FAP_CTRL_SECLOCK]),
        .allow_o        (allow),
        .sec_hit_o      (sec_hit)
    );

    fap_ecc u_ecc (
        .enc_data_i   ((state_reg == ST_BLANK) ? wdata_hold_reg : req_wdata_i),
        .enc_check_o  (enc_check),
        .dec_word_i   (fl_rdata_i),
        .dec_data_o   (dec_data),
        .dec_single_o (dec_single),
        .dec_double_o (dec_double)
    );

    // Pin synchronisers
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
        end else begin
            sync1_reg <= {boot_alt_i, dbg_attached_i};
            sync2_reg <= sync1_reg;
        end
    end

    // APB slave, no wait states
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= apb_setup;
            pslverr_reg <= apb_setup & (~hit_any | (pwrite_i & hit_level & lvl_refused));
            prdata_reg  <= (apb_setup & ~pwrite_i) ? rd_mux : 32'h0;
        end
    end

    // Configuration registers; level is loaded from the option word after reset
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            loaded_reg <= 1'b0;
            level_reg  <= `FAP_LVL2_CODE;
            ctrl_reg   <= 2'h0;
            wlock_reg  <= `FAP_WLOCK_RST;
            xo_reg     <= `FAP_XO_RST;
            sec_reg    <= `FAP_SEC_RST;
            irqen_reg  <= 5'h00;
        end else begin
            loaded_reg <= 1'b1;
            if (!loaded_reg) level_reg <= opt_level_i;
            else if (lvl_wr) level_reg <= pwdata_i[7:0];
            if (apb_wr & hit_ctrl) begin
                ctrl_reg[`FAP_CTRL_SECLOCK] <= ctrl_reg[`FAP_CTRL_SECLOCK] | pwdata_i[`FAP_CTRL_SECLOCK];
                ctrl_reg[`FAP_CTRL_XOWIPE]  <= pwdata_i[`FAP_CTRL_XOWIPE];
            end
            if (apb_wr & hit_wlock) wlock_reg <= {18'h0, pwdata_i[13:8], 2'h0, pwdata_i[5:0]};
            if (apb_wr & hit_xo) xo_reg <= {18'h0, pwdata_i[13:8], 2'h0, pwdata_i[5:0]};
            if (apb_wr & hit_sec) sec_reg <= {25'h0, pwdata_i[6:0]};
            if (apb_wr & hit_irqen) irqen_reg <= pwdata_i[4:0];
        end
    end

    // Sticky status, set wins over clear; interrupt and level-derived outputs
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            status_reg    <= 5'h00;
            irq_reg       <= 1'b0;
            wipe_pend_reg <= 1'b0;
            dbg_off_reg   <= 1'b1;
            boot_lock_reg <= 1'b1;
        end else begin
            status_reg    <= (status_reg & ~clr_mask) | ev_reg;
            irq_reg       <= |(status_reg & irqen_reg);
            wipe_pend_reg <= (wipe_pend_reg & ~wipe_done) | wipe_req;
            dbg_off_reg   <= lvl2;
            boot_lock_reg <= lvl2;
        end
    end

    // Request sequencer towards the flash array
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg      <= ST_IDLE;
            req_ready_reg  <= 1'b0;
            rsp_valid_reg  <= 1'b0;
            rsp_err_reg    <= 1'b0;
            rsp_rdata_reg  <= 64'h0;
            fl_req_reg     <= 1'b0;
            fl_op_reg      <= OP_READ;
            fl_addr_reg    <= '0;
            fl_wdata_reg   <= 72'h0;
            eccaddr_reg    <= '0;
            ev_reg         <= 5'h00;
            wdata_hold_reg <= 64'h0;
        end else begin
            rsp_valid_reg <= 1'b0;
            ev_reg        <= 5'h00;
            unique case (state_reg)
                ST_IDLE: begin
                    req_ready_reg <= ~wipe_pend_reg & ~take;
                    if (wipe_pend_reg) begin
                        fl_req_reg  <= 1'b1;
                        fl_op_reg   <= OP_WIPE;
                        fl_addr_reg <= {1'b0, xo_reg[5:0], 11'h0};
                        state_reg   <= ST_WIPE;
                    end else if (take && !allow) begin
                        rsp_valid_reg          <= 1'b1;
                        rsp_err_reg            <= 1'b1;
                        rsp_rdata_reg          <= 64'h0;
                        ev_reg[`FAP_ST_DENY]   <= 1'b1;
                        ev_reg[`FAP_ST_SEC]    <= sec_hit;
                        req_ready_reg          <= 1'b1;
                    end else if (take) begin
                        fl_req_reg     <= 1'b1;
                        fl_addr_reg    <= req_addr_i;
                        wdata_hold_reg <= req_wdata_i;
                        fl_wdata_reg   <= {enc_check, req_wdata_i};
                        if (req_op_i == OP_READ) begin
                            fl_op_reg <= OP_READ;
                            state_reg <= ST_READ;
                        end else if (req_op_i == OP_PROG && req_addr_i[`FAP_OTP_BIT]) begin
                            fl_op_reg <= OP_READ;
                            state_reg <= ST_BLANK;
                        end else begin
                            fl_op_reg <= req_op_i;
                            state_reg <= ST_WRITE;
                        end
                    end
                end
                ST_READ: begin
                    if (fl_ack_i) begin
                        fl_req_reg           <= 1'b0;
                        rsp_valid_reg        <= 1'b1;
                        rsp_err_reg          <= dec_double;
                        rsp_rdata_reg        <= dec_data;
                        ev_reg[`FAP_ST_ECC1] <= dec_single;
                        ev_reg[`FAP_ST_ECC2] <= dec_double;
                        if (dec_single | dec_double) eccaddr_reg <= fl_addr_reg;
                        req_ready_reg        <= ~wipe_pend_reg;
                        state_reg            <= ST_IDLE;
                    end
                end
                ST_BLANK: begin
                    if (fl_ack_i && blank) begin
                        fl_op_reg    <= OP_PROG;
                        fl_wdata_reg <= {enc_check, wdata_hold_reg};
                        state_reg    <= ST_WRITE;
                    end else if (fl_ack_i) begin
                        fl_req_reg           <= 1'b0;
                        rsp_valid_reg        <= 1'b1;
                        rsp_err_reg          <= 1'b1;
                        rsp_rdata_reg        <= 64'h0;
                        ev_reg[`FAP_ST_DENY] <= 1'b1;
                        req_ready_reg        <= ~wipe_pend_reg;
                        state_reg            <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (fl_ack_i) begin
                        fl_req_reg        <= 1'b0;
                        rsp_valid_reg     <= 1'b1;
                        rsp_err_reg       <= 1'b0;
                        rsp_rdata_reg     <= 64'h0;
                        ev_reg[`FAP_ST_W] <= 1'b1;
                        req_ready_reg     <= ~wipe_pend_reg;
                        state_reg         <= ST_IDLE;
                    end
                end
                ST_WIPE: begin
                    if (fl_ack_i) begin
                        fl_req_reg    <= 1'b0;
                        req_ready_reg <= 1'b1;
                        state_reg     <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign prdata_o        = prdata_reg;
    assign pready_o        = pready_reg;
    assign pslverr_o       = pslverr_reg;
    assign req_ready_o     = req_ready_reg;
    assign rsp_valid_o     = rsp_valid_reg;
    assign rsp_err_o       = rsp_err_reg;
    assign rsp_rdata_o     = rsp_rdata_reg;
    assign fl_req_o        = fl_req_reg;
    assign fl_op_o         = fl_op_reg;
    assign fl_addr_o       = fl_addr_reg;
    assign fl_wdata_o      = fl_wdata_reg;
    assign dbg_port_off_o  = dbg_off_reg;
    assign boot_sel_lock_o = boot_lock_reg;
    assign irq_o           = irq_reg;
endmodule : fap_top

// >>> verif/fap_top_chk.sv
// Port assertions for fap_top, attached by bind.
// Assumes one clock domain and an active-high reset.
`timescale 1ns/1ps
`include "fap_consts.svh"
module fap_top_chk
    import fap_pkg::*;
(
    input logic        clock_i,
    input logic        rst_i,
    input logic        req_valid_i,
    input fap_master_t req_master_i,
    input logic        req_ready_o,
    input logic        rsp_valid_o,
    input logic        rsp_err_o,
    input logic        fl_req_o,
    input fap_op_t     fl_op_o,
    input logic [17:0] fl_addr_o,
    input logic        fl_ack_i,
    input logic        dbg_port_off_o,
    input logic        boot_sel_lock_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    sequence s_refused;
        rsp_valid_o && rsp_err_o && !fl_req_o;
    endsequence
    a_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o) else $error("long response");
    a_rsp_ready: assert property (rsp_valid_o |-> req_ready_o) else $error("not ready");
    a_take_busy: assert property (req_valid_i && req_ready_o |=> !req_ready_o || (rsp_valid_o && rsp_err_o))
        else $error("ready held");
    a_fl_hold: assert property (fl_req_o && !fl_ack_i |=> fl_req_o && $stable(fl_addr_o))
        else $error("array request dropped");
    a_read_rsp: assert property (fl_ack_i && fl_op_o == OP_READ && !fl_addr_o[`FAP_OTP_BIT] |=> rsp_valid_o)
        else $error("read not answered");
    a_otp_ops: assert property (fl_req_o && fl_addr_o[`FAP_OTP_BIT] |-> fl_op_o inside {OP_READ, OP_PROG})
        else $error("otp erased");
    a_lvl2_pair: assert property (dbg_port_off_o == boot_sel_lock_o) else $error("lock outputs differ");
    a_debug_off: assert property (req_valid_i && req_ready_o && req_master_i == MST_DEBUG && dbg_port_off_o
        |=> s_refused) else $error("debug not refused");
endmodule : fap_top_chk
bind fap_top fap_top_chk u_chk (.*);

// >>> verif/fap_flash_model.sv
// Behavioural flash array behind the protection block.
// Assumes the same clock; flip_i injects bit errors into reads.
`timescale 1ns/1ps
module fap_flash_model
    import fap_pkg::*;
(
    input  logic        clock_i,
    input  logic        fl_req_i,
    input  fap_op_t     fl_op_i,
    input  logic [17:0] fl_addr_i,
    input  logic [71:0] fl_wdata_i,
    input  logic [1:0]  flip_i,
    output logic        fl_ack_o,
    output logic [71:0] fl_rdata_o
);
    logic [71:0] mem [0:63];
    logic [1:0]  wait_reg;
    wire  [5:0]  idx = {fl_addr_i[17], fl_addr_i[7:3]};
    initial begin
        foreach (mem[i]) mem[i] = '1;
        fl_ack_o   = 1'b0;
        fl_rdata_o = '0;
        wait_reg   = 2'h0;
    end
    // Reads answer at once, other operations two cycles late
    always @(posedge clock_i) begin
        fl_ack_o   <= 1'b0;
        fl_rdata_o <= ~fl_rdata_o;
        wait_reg   <= (fl_req_i && !fl_ack_o) ? wait_reg + 2'h1 : 2'h0;
        if (fl_req_i && !fl_ack_o && (wait_reg[1] || fl_op_i == OP_READ)) begin
            fl_ack_o <= 1'b1;
            case (fl_op_i)
                OP_READ: fl_rdata_o <= mem[idx] ^ 72'(flip_i ^ {1'b0, flip_i[1]});
                OP_PROG: mem[idx] <= mem[idx] & fl_wdata_i;
                default: mem[idx] <= '1;
            endcase
        end
    end
endmodule : fap_flash_model

// >>> verif/tb_flash_access_protection.sv
// Self-checking bench for fap_top with a flash array model.
// Assumes fap_top_chk and fap_flash_model compile alongside.
`timescale 1ns/1ps
`include "fap_consts.svh"
module tb_flash_access_protection
    import fap_pkg::*;
;
    logic clock_i, rst_i, dbg_attached_i, boot_alt_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic req_valid_i, req_ready_o, rsp_valid_o, rsp_err_o, fl_req_o, fl_ack_i, dbg_port_off_o, boot_sel_lock_o, irq_o;
    logic [1:0]  flip;
    logic [7:0]  opt_level_i, paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [17:0] req_addr_i, fl_addr_o;
    logic [63:0] req_wdata_i, rsp_rdata_o;
    logic [71:0] fl_wdata_o, fl_rdata_i;
    fap_master_t req_master_i;
    fap_op_t     req_op_i, fl_op_o;
    int          n_errors, samples_checked;
    localparam logic [17:0] A = 18'h00008;
    localparam logic [63:0] D = 64'h0123_4567_89ab_cdef;
    fap_top dut (.*);
    fap_flash_model u_flash (.clock_i, .fl_req_i(fl_req_o), .fl_op_i(fl_op_o), .fl_addr_i(fl_addr_o),
        .fl_wdata_i(fl_wdata_o), .flip_i(flip), .fl_ack_o(fl_ack_i), .fl_rdata_o(fl_rdata_i));
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic complete_run;
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    task automatic rst(input logic [7:0] lvl);
        @(posedge clock_i);
        opt_level_i <= lvl;
        rst_i       <= 1'b1;
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask : rst
    task automatic apb(input logic wr, logic [7:0] a, logic [31:0] d, xd = 0, logic xe = 0);
        @(posedge clock_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= d;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do @(posedge clock_i); while (pready_o !== 1'b1);
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
        chk(pslverr_o, xe);
        if (!wr) chk(prdata_o, xd);
    endtask : apb
    task automatic acc(input fap_master_t m, fap_op_t o, logic [17:0] a, logic xe);
        repeat (3) @(posedge clock_i);
        req_valid_i  <= 1'b1;
        req_master_i <= m;
        req_op_i     <= o;
        req_addr_i   <= a;
        req_wdata_i  <= D;
        do @(posedge clock_i); while (req_ready_o !== 1'b1);
        req_valid_i <= 1'b0;
        do @(posedge clock_i); while (rsp_valid_o !== 1'b1);
        chk(rsp_err_o, xe);
        if (o == OP_READ && !xe) chk(rsp_rdata_o, D);
    endtask : acc
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        {rst_i, dbg_attached_i, boot_alt_i, psel_i, penable_i, pwrite_i, req_valid_i, flip} = '0;
        {opt_level_i, paddr_i, pwdata_i, req_addr_i, req_wdata_i} = '0;
        req_master_i = MST_CPU_I;
        req_op_i     = OP_READ;
        rst(8'haa);
        apb(0, `FAP_OFS_WLOCK, 0, `FAP_WLOCK_RST);
        apb(0, 8'h30, 0, 0, 1);
        acc(MST_DMA, OP_PROG, A, 0);
        acc(MST_DMA, OP_READ, A, 0);
        flip <= 2'h1;
        acc(MST_CPU_D, OP_READ, A, 0);
        apb(0, `FAP_OFS_ECCADDR, 0, 32'(A));
        flip <= 2'h2;
        acc(MST_CPU_D, OP_READ, A, 1);
        flip <= 2'h0;
        apb(1, `FAP_OFS_WLOCK, 0);
        acc(MST_CPU_D, OP_ERASE, A, 1);
        acc(MST_CPU_D, OP_READ, A, 0);
        apb(1, `FAP_OFS_XO, 0);
        acc(MST_CPU_I, OP_READ, A, 0);
        acc(MST_DMA, OP_READ, A, 1);
        apb(1, `FAP_OFS_XO, `FAP_XO_RST);
        apb(1, `FAP_OFS_IRQEN, 32'h1);
        apb(1, `FAP_OFS_SEC, 32'h1);
        apb(1, `FAP_OFS_CTRL, 32'h1);
        acc(MST_CPU_I, OP_READ, A, 1);
        apb(0, `FAP_OFS_STATUS, 0, 32'h1f);
        chk(irq_o, 1);
        apb(1, `FAP_OFS_CLEAR, 32'h1f);
        apb(0, `FAP_OFS_STATUS, 0, 0);
        chk(irq_o, 0);
        boot_alt_i <= 1'b1;
        rst(8'h00);
        acc(MST_CPU_I, OP_READ, A, 1);
        boot_alt_i     <= 1'b0;
        dbg_attached_i <= 1'b1;
        acc(MST_CPU_D, OP_READ, A, 1);
        dbg_attached_i <= 1'b0;
        acc(MST_CPU_I, OP_READ, A, 0);
        acc(MST_CPU_D, OP_PROG, 18'h20000, 0);
        acc(MST_CPU_D, OP_PROG, 18'h20000, 1);
        acc(MST_CPU_D, OP_ERASE, 18'h20000, 1);
        acc(MST_CPU_D, OP_PROG, 18'h0, 0);
        apb(1, `FAP_OFS_CTRL, 32'h2);
        apb(1, `FAP_OFS_LEVEL, 32'haa);
        acc(MST_CPU_I, OP_READ, A, 0);
        chk(u_flash.mem[0][63:0], '1);
        rst(8'hcc);
        chk(dbg_port_off_o, 1);
        apb(1, `FAP_OFS_LEVEL, 32'haa, 0, 1);
        acc(MST_DEBUG, OP_READ, A, 1);
        acc(MST_CPU_D, OP_READ, A, 0);
        complete_run;
    end
    initial begin
        repeat (5000) @(posedge clock_i);
        n_errors++;
        complete_run;
    end
endmodule : tb_flash_access_protection
